// >>> rtl/smc_arbiter.sv
`timescale 1ns/1ps

module smc_arbiter #(
    parameter int N = smc_pkg::NUM_MASTERS,
    parameter int PW = smc_pkg::PRIO_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] done,
    input wire logic [N*PW-1:0] prio,
    output logic [N-1:0] gnt_ff
);

    if (N < 1 || N > 16 || PW < 1 || PW > 8) begin : g_bad_params
        $error("smc_arbiter: unsupported master count or width");
    end

    // Highest value wins; strict compare keeps lower index on ties
    function automatic logic [N-1:0] pick(
        input logic [N-1:0] r,
        input logic [N*PW-1:0] p
    );
        logic [N-1:0] win;
        logic [PW-1:0] best;
        logic found;
        win = '0;
        best = '0;
        found = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (r[i] && (!found || p[i*PW +: PW] > best)) begin
                win = '0;
                win[i] = 1'b1;
                best = p[i*PW +: PW];
                found = 1'b1;
            end
        end
        return win;
    endfunction : pick

    logic owner_busy;
    logic owner_done;
    logic [N-1:0] nxt_gnt;

    assign owner_busy = |(gnt_ff & req);
    assign owner_done = |(gnt_ff & done);

    always_comb begin
        nxt_gnt = gnt_ff;
        if (!owner_busy || owner_done) begin
            nxt_gnt = pick(req, prio);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gnt_ff <= '0;
        end else begin
            gnt_ff <= nxt_gnt;
        end
    end

endmodule : smc_arbiter

// >>> rtl/smc_controller.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Per-master priority 0..7, highest value wins
// - Equal priorities: master 0 first, 3 last
// - Core 0, DMA 1, USB host 2, Ethernet 3
// - Top nibble picks 256-Mbyte region
// - Each external region drives own chip select
// - Undefined 1536-Mbyte space answers with abort
// - Internal area decodes 1-Mbyte aliased slots
// - Internal access at or above 0x0040_0000 aborts
// - Boot slot aliases ROM or chip select zero
// - Remapped boot slot aliases SRAM, original kept
// - Boot level latched over last reset cycles
// - Writing one toggles remap; zero ignored
// - Abort broadcast to all masters
// - Abort captures full failing address
// - Abort records size, type and cause
// - Last-source flag per master, updated each abort
// - Sticky per-master flags, cleared by status read
// - Misaligned word or half-word access aborts
// - Core instruction fetches skip alignment check
// - Little-endian transfers only
// - Refresh interrupt passes through, no own interrupt
module smc_controller (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic boot_select_pin,
    input wire logic [3:0] bus_req,
    input wire logic [3:0] xfer_done,
    input wire logic [3:0] acc_valid,
    input wire logic [3:0][31:0] acc_addr,
    input wire logic [3:0][1:0] acc_size,
    input wire logic [3:0][1:0] acc_kind,
    input wire logic prio_wr,
    input wire logic [11:0] prio_wdata,
    input wire logic remap_wr,
    input wire logic remap_toggle_bit,
    input wire logic status_rd,
    input wire logic ebi_refresh_irq,
    output logic [3:0] bus_gnt_ff,
    output logic abort_ff,
    output logic sel_valid_ff,
    output logic [7:0] ext_cs_ff,
    output logic periph_sel_ff,
    output logic rom_sel_ff,
    output logic sram_sel_ff,
    output logic area3_sel_ff,
    output logic [31:0] sel_addr_ff,
    output logic [11:0] master_priority_reg_ff,
    output logic remap_state_ff,
    output logic boot_latched_ff,
    output logic [31:0] abort_address_reg_ff,
    output logic [1:0] abort_size_field_ff,
    output logic [1:0] abort_type_field_ff,
    output logic undefined_address_flag_ff,
    output logic misaligned_access_flag_ff,
    output logic last_source_core_flag_ff,
    output logic last_source_dma_flag_ff,
    output logic last_source_usbhost_flag_ff,
    output logic last_source_ethernet_flag_ff,
    output logic sticky_core_abort_flag_ff,
    output logic sticky_dma_abort_flag_ff,
    output logic sticky_usbhost_abort_flag_ff,
    output logic sticky_ethernet_abort_flag_ff,
    output logic mc_irq_ff
);

    localparam int NM = smc_pkg::NUM_MASTERS;

    logic boot_meta_ff;
    logic boot_sync_ff;
    logic [NM-1:0] arb_gnt;
    logic [3:0] last_src_ff;
    logic [3:0] sticky_ff;
    logic last_unread_ff;

    // Selected owner's access
    logic own_valid;
    logic [31:0] own_addr;
    logic [1:0] own_size;
    logic [1:0] own_kind;
    logic [3:0] own_idx;

    // Decode results
    logic dec_undef;
    logic dec_misalign;
    logic dec_abort;
    logic [7:0] dec_cs;
    logic dec_periph;
    logic dec_internal;
    smc_pkg::smc_target_t dec_tgt;
    logic [31:0] dec_addr;

    // Arbitration
    smc_arbiter #(
        .N(smc_pkg::NUM_MASTERS),
        .PW(smc_pkg::PRIO_W)
    ) u_arbiter (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .req(bus_req),
        .done(xfer_done),
        .prio(master_priority_reg_ff),
        .gnt_ff(arb_gnt)
    );

    // Grant seen by the masters, one edge behind the arbiter
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bus_gnt_ff <= 4'h0;
        end else begin
            bus_gnt_ff <= arb_gnt;
        end
    end

    // Priority fields, master 0 in the low three bits
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            master_priority_reg_ff <= smc_pkg::PRIO_RST;
        end else if (prio_wr) begin
            master_priority_reg_ff <= prio_wdata;
        end
    end

    // Boot level sync; latch follows it while reset is held
    always_ff @(posedge ref_clk) begin
        boot_meta_ff <= boot_select_pin;
        boot_sync_ff <= boot_meta_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            boot_latched_ff <= boot_sync_ff;
        end
    end

    // Only a written one flips the page zero mapping
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            remap_state_ff <= 1'b0;
        end else if (remap_wr && remap_toggle_bit) begin
            remap_state_ff <= ~remap_state_ff;
        end
    end

    // Only the granted master's lane is looked at
    function automatic logic [3:0] onehot_to_idx(input logic [3:0] oh);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (oh[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : onehot_to_idx

    always_comb begin
        own_idx = onehot_to_idx(bus_gnt_ff);
        own_valid = |(bus_gnt_ff & acc_valid);
        own_addr = acc_addr[own_idx[1:0]];
        own_size = acc_size[own_idx[1:0]];
        own_kind = acc_kind[own_idx[1:0]];
    end

    // Alignment check
    function automatic logic misaligned(
        input logic [1:0] size,
        input logic [1:0] low
    );
        logic bad;
        bad = 1'b0;
        if (size == smc_pkg::SIZE_WORD) begin
            bad = (low != 2'h0);
        end else if (size == smc_pkg::SIZE_HALF) begin
            bad = low[0];
        end
        return bad;
    endfunction : misaligned

    always_comb begin
        dec_misalign = misaligned(own_size, own_addr[1:0]);
        if (own_idx == 4'(smc_pkg::MST_CORE) &&
            own_kind == smc_pkg::KIND_FETCH) begin
            dec_misalign = 1'b0;
        end
    end

    // Address decode
    always_comb begin
        logic [3:0] nib;
        logic [7:0] slot;
        nib = own_addr[31:28];
        slot = own_addr[smc_pkg::SLOT_LSB +: smc_pkg::SLOT_W];
        dec_undef = 1'b0;
        dec_cs = 8'h00;
        dec_periph = 1'b0;
        dec_internal = 1'b0;
        dec_tgt = smc_pkg::SMC_TGT_ROM;
        dec_addr = own_addr;
        if (nib == smc_pkg::REGION_INTERNAL) begin
            dec_internal = 1'b1;
            // Low 20 bits only: each memory repeats in its slot
            dec_addr = {12'h000, own_addr[19:0]};
            case (slot)
                smc_pkg::SLOT_BOOT: begin
                    if (remap_state_ff) begin
                        dec_tgt = smc_pkg::SMC_TGT_SRAM;
                    end else if (boot_latched_ff) begin
                        dec_tgt = smc_pkg::SMC_TGT_ROM;
                    end else begin
                        dec_tgt = smc_pkg::SMC_TGT_EXT0;
                    end
                end
                smc_pkg::SLOT_ROM: dec_tgt = smc_pkg::SMC_TGT_ROM;
                smc_pkg::SLOT_SRAM: dec_tgt = smc_pkg::SMC_TGT_SRAM;
                smc_pkg::SLOT_AREA3: dec_tgt = smc_pkg::SMC_TGT_AREA3;
                default: begin
                    dec_internal = 1'b0;
                    dec_undef = 1'b1;
                end
            endcase
            if (dec_internal && dec_tgt == smc_pkg::SMC_TGT_EXT0) begin
                dec_cs[0] = 1'b1;
            end
        end else if (nib >= smc_pkg::REGION_EXT_FIRST &&
                     nib <= smc_pkg::REGION_EXT_LAST) begin
            dec_cs[3'(nib - smc_pkg::REGION_EXT_FIRST)] = 1'b1;
            dec_addr = {4'h0, own_addr[27:0]};
        end else if (nib == smc_pkg::REGION_PERIPH) begin
            dec_periph = 1'b1;
        end else begin
            dec_undef = 1'b1;
        end
        dec_abort = dec_undef || dec_misalign;
    end

    // Selects for a good access, one cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sel_valid_ff <= 1'b0;
            ext_cs_ff <= 8'h00;
            periph_sel_ff <= 1'b0;
            rom_sel_ff <= 1'b0;
            sram_sel_ff <= 1'b0;
            area3_sel_ff <= 1'b0;
            sel_addr_ff <= 32'h0000_0000;
        end else begin
            sel_valid_ff <= own_valid && !dec_abort;
            ext_cs_ff <= (own_valid && !dec_abort) ? dec_cs : 8'h00;
            periph_sel_ff <= own_valid && !dec_abort && dec_periph;
            rom_sel_ff <= own_valid && !dec_abort && dec_internal &&
                dec_tgt == smc_pkg::SMC_TGT_ROM;
            sram_sel_ff <= own_valid && !dec_abort && dec_internal &&
                dec_tgt == smc_pkg::SMC_TGT_SRAM;
            area3_sel_ff <= own_valid && !dec_abort && dec_internal &&
                dec_tgt == smc_pkg::SMC_TGT_AREA3;
            // Byte lanes passed unswapped: little-endian only
            if (own_valid) begin
                sel_addr_ff <= dec_addr;
            end
        end
    end

    // Abort to every master; only the owner acts on it
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            abort_ff <= 1'b0;
        end else begin
            abort_ff <= own_valid && dec_abort;
        end
    end

    // Abort capture
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            abort_address_reg_ff <= smc_pkg::ABORT_ADDR_RST;
            abort_size_field_ff <= smc_pkg::FIELD2_RST;
            abort_type_field_ff <= smc_pkg::FIELD2_RST;
            undefined_address_flag_ff <= 1'b0;
            misaligned_access_flag_ff <= 1'b0;
        end else if (own_valid && dec_abort) begin
            abort_address_reg_ff <= own_addr;
            abort_size_field_ff <= own_size;
            abort_type_field_ff <= own_kind;
            undefined_address_flag_ff <= dec_undef;
            misaligned_access_flag_ff <= dec_misalign;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            last_src_ff <= smc_pkg::FLAGS_RST;
        end else if (own_valid && dec_abort) begin
            last_src_ff <= bus_gnt_ff;
        end
    end

    // Previous last source moves to sticky only if not yet read
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            last_unread_ff <= 1'b0;
        end else if (own_valid && dec_abort) begin
            last_unread_ff <= 1'b1;
        end else if (status_rd) begin
            last_unread_ff <= 1'b0;
        end
    end

    // Set wins over the read clear
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sticky_ff <= smc_pkg::FLAGS_RST;
        end else begin
            sticky_ff <= (status_rd ? 4'h0 : sticky_ff) |
                ((own_valid && dec_abort && last_unread_ff) ?
                 last_src_ff : 4'h0);
        end
    end

    always_comb begin
        last_source_core_flag_ff = last_src_ff[smc_pkg::MST_CORE];
        last_source_dma_flag_ff = last_src_ff[smc_pkg::MST_DMA];
        last_source_usbhost_flag_ff = last_src_ff[smc_pkg::MST_USBHOST];
        last_source_ethernet_flag_ff = last_src_ff[smc_pkg::MST_ETHERNET];
        sticky_core_abort_flag_ff = sticky_ff[smc_pkg::MST_CORE];
        sticky_dma_abort_flag_ff = sticky_ff[smc_pkg::MST_DMA];
        sticky_usbhost_abort_flag_ff = sticky_ff[smc_pkg::MST_USBHOST];
        sticky_ethernet_abort_flag_ff = sticky_ff[smc_pkg::MST_ETHERNET];
    end

    // Refresh error simply transits, registered
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mc_irq_ff <= 1'b0;
        end else begin
            mc_irq_ff <= ebi_refresh_irq;
        end
    end

endmodule : smc_controller

// >>> rtl/smc_pkg.sv
package smc_pkg;

    localparam int NUM_MASTERS = 4;
    localparam int PRIO_W = 3;
    localparam int NUM_EXT_CS = 8;

    // Master indices
    localparam int MST_CORE = 0;
    localparam int MST_DMA = 1;
    localparam int MST_USBHOST = 2;
    localparam int MST_ETHERNET = 3;

    // Priority reset values, one field per master
    localparam logic [PRIO_W-1:0] PRIO_RST_CORE = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_RST_DMA = 3'h1;
    localparam logic [PRIO_W-1:0] PRIO_RST_USBHOST = 3'h2;
    localparam logic [PRIO_W-1:0] PRIO_RST_ETHERNET = 3'h3;
    localparam logic [NUM_MASTERS*PRIO_W-1:0] PRIO_RST =
        {PRIO_RST_ETHERNET, PRIO_RST_USBHOST, PRIO_RST_DMA, PRIO_RST_CORE};

    // Top address nibble regions
    localparam logic [3:0] REGION_INTERNAL = 4'h0;
    localparam logic [3:0] REGION_EXT_FIRST = 4'h1;
    localparam logic [3:0] REGION_EXT_LAST = 4'h8;
    localparam logic [3:0] REGION_PERIPH = 4'hf;

    // Internal 1-Mbyte slots, decoded from bits 27:20
    localparam int SLOT_LSB = 20;
    localparam int SLOT_W = 8;
    localparam logic [7:0] SLOT_BOOT = 8'h00;
    localparam logic [7:0] SLOT_ROM = 8'h01;
    localparam logic [7:0] SLOT_SRAM = 8'h02;
    localparam logic [7:0] SLOT_AREA3 = 8'h03;
    localparam logic [7:0] SLOT_LAST_DEFINED = 8'h03;

    // Access size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Access type codes
    localparam logic [1:0] KIND_READ = 2'h0;
    localparam logic [1:0] KIND_WRITE = 2'h1;
    localparam logic [1:0] KIND_FETCH = 2'h2;

    // Reset values of status
    localparam logic [31:0] ABORT_ADDR_RST = 32'h0000_0000;
    localparam logic [1:0] FIELD2_RST = 2'h0;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    typedef enum logic [1:0] {
        SMC_TGT_ROM,
        SMC_TGT_SRAM,
        SMC_TGT_AREA3,
        SMC_TGT_EXT0
    } smc_target_t;

endpackage : smc_pkg

// >>> tb/smc_master_model.sv
`timescale 1ns/1ps
module smc_master_model (
    input wire logic ref_clk,
    input wire logic [3:0] bus_gnt_ff,
    output logic [3:0] bus_req,
    output logic [3:0] xfer_done,
    output logic [3:0] acc_valid,
    output logic [3:0][31:0] acc_addr,
    output logic [3:0][1:0] acc_size,
    output logic [3:0][1:0] acc_kind
);
    initial begin
        bus_req = 4'h0;
        xfer_done = 4'h0;
        acc_valid = 4'h0;
        acc_addr = '0;
        acc_size = '0;
        acc_kind = '0;
    end

    // One little-endian access by master m, answer left standing
    task automatic access(input int m, input logic [31:0] a,
        input logic [1:0] sz, input logic [1:0] kd, output bit ok);
        int n;
        for (n = 0; n < 16 && bus_gnt_ff !== 4'h0; n++) @(negedge ref_clk);
        bus_req[m] = 1'b1;
        for (n = 0; n < 16 && bus_gnt_ff[m] !== 1'b1; n++) @(negedge ref_clk);
        ok = bus_gnt_ff[m] === 1'b1;
        acc_valid[m] = 1'b1;
        acc_addr[m] = a;
        acc_size[m] = sz;
        acc_kind[m] = kd;
        @(negedge ref_clk);
    endtask : access

    // Ends the access: bus released, transfer marked done
    task automatic finish_access(input int m);
        acc_valid[m] = 1'b0;
        acc_addr[m] = ~acc_addr[m];
        bus_req[m] = 1'b0;
        xfer_done[m] = 1'b1;
        @(negedge ref_clk);
        xfer_done[m] = 1'b0;
    endtask : finish_access

    // Contention: masters in mask request together, winner holds a while
    task automatic contend(input logic [3:0] mask, output logic [3:0] g);
        int n;
        for (n = 0; n < 16 && bus_gnt_ff !== 4'h0; n++) @(negedge ref_clk);
        bus_req = mask;
        for (n = 0; n < 16 && bus_gnt_ff === 4'h0; n++) @(negedge ref_clk);
        g = bus_gnt_ff;
        repeat (3) @(negedge ref_clk);
        if (bus_gnt_ff !== g) begin
            g = 4'h0;
        end
        bus_req = 4'h0;
        xfer_done = mask & g;
        @(negedge ref_clk);
        xfer_done = 4'h0;
    endtask : contend
endmodule : smc_master_model

// >>> tb/smc_properties.sv
`timescale 1ns/1ps
module smc_properties (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] bus_req,
    input wire logic [3:0] xfer_done,
    input wire logic [3:0] acc_valid,
    input wire logic [3:0][31:0] acc_addr,
    input wire logic [3:0][1:0] acc_size,
    input wire logic [3:0][1:0] acc_kind,
    input wire logic remap_wr,
    input wire logic remap_toggle_bit,
    input wire logic ebi_refresh_irq,
    input wire logic [3:0] bus_gnt_ff,
    input wire logic abort_ff,
    input wire logic sel_valid_ff,
    input wire logic [7:0] ext_cs_ff,
    input wire logic undefined_address_flag_ff,
    input wire logic misaligned_access_flag_ff,
    input wire logic [31:0] abort_address_reg_ff,
    input wire logic remap_state_ff,
    input wire logic mc_irq_ff
);
    logic [1:0] gi;
    logic [31:0] ga;
    logic [7:0] cs_exp;
    logic take, mis, fx, ext, und, keep;
    always_comb begin
        gi = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (bus_gnt_ff[i]) begin
                gi = 2'(i);
            end
        end
    end
    assign ga = acc_addr[gi];
    assign take = |(acc_valid & bus_gnt_ff);
    assign mis = (acc_size[gi] == smc_pkg::SIZE_WORD && ga[1:0] != 2'h0)
        || (acc_size[gi] == smc_pkg::SIZE_HALF && ga[0]);
    assign fx = gi == 2'h0 && acc_kind[gi] == smc_pkg::KIND_FETCH;
    assign ext = ga[31:28] >= 4'h1 && ga[31:28] <= 4'h8;
    assign und = (ga[31:28] >= 4'h9 && ga[31:28] <= 4'he)
        || (ga[31:28] == 4'h0 && ga[27:20] > 8'h03);
    assign cs_exp = 8'h01 << (ga[31:28] - 4'h1);
    assign keep = bus_gnt_ff != 4'h0 && (bus_gnt_ff & ~bus_req) == 4'h0
        && (bus_gnt_ff & xfer_done) == 4'h0;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_take;
        take;
    endsequence
    sequence s_held;
        keep [*2];
    endsequence

    answer_once_a: assert property (
        s_take |=> abort_ff ^ sel_valid_ff)
        else $error("access answer is not exactly one of select or abort");
    undef_abort_a: assert property (
        s_take ##0 und |=> abort_ff && undefined_address_flag_ff)
        else $error("undefined address not aborted");
    misalign_abort_a: assert property (
        s_take ##0 (mis && !fx) |=> abort_ff && misaligned_access_flag_ff)
        else $error("misaligned access not aborted");
    fetch_exempt_a: assert property (
        s_take ##0 (fx && ext) |=> sel_valid_ff && !abort_ff)
        else $error("core fetch was aborted");
    ext_select_a: assert property (
        s_take ##0 (ext && !mis) |=> ext_cs_ff == $past(cs_exp))
        else $error("wrong external chip select");
    abort_addr_a: assert property (
        abort_ff |-> abort_address_reg_ff == $past(ga))
        else $error("abort address not captured");
    remap_flip_a: assert property (
        remap_wr && remap_toggle_bit |=> remap_state_ff != $past(remap_state_ff))
        else $error("remap state did not toggle");
    irq_pass_a: assert property (
        1'b1 |=> mc_irq_ff == $past(ebi_refresh_irq))
        else $error("refresh interrupt not passed through");
    grant_hold_a: assert property (
        s_held |=> $stable(bus_gnt_ff))
        else $error("grant moved during a transfer");
endmodule : smc_properties

bind smc_controller smc_properties i_smc_properties (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req),
    .xfer_done(xfer_done), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_size(acc_size), .acc_kind(acc_kind), .remap_wr(remap_wr),
    .remap_toggle_bit(remap_toggle_bit), .ebi_refresh_irq(ebi_refresh_irq),
    .bus_gnt_ff(bus_gnt_ff), .abort_ff(abort_ff),
    .sel_valid_ff(sel_valid_ff), .ext_cs_ff(ext_cs_ff),
    .undefined_address_flag_ff(undefined_address_flag_ff),
    .misaligned_access_flag_ff(misaligned_access_flag_ff),
    .abort_address_reg_ff(abort_address_reg_ff),
    .remap_state_ff(remap_state_ff), .mc_irq_ff(mc_irq_ff)
);

// >>> tb/system_bus_memory_controller_bench.sv
`timescale 1ns/1ps
module system_bus_memory_controller_bench;
    localparam logic [1:0] B = smc_pkg::SIZE_BYTE;
    localparam logic [1:0] H = smc_pkg::SIZE_HALF;
    localparam logic [1:0] W = smc_pkg::SIZE_WORD;
    localparam logic [1:0] RD = smc_pkg::KIND_READ;
    localparam logic [1:0] WR = smc_pkg::KIND_WRITE;
    localparam logic [1:0] FE = smc_pkg::KIND_FETCH;
    logic ref_clk, rst_b, boot_select_pin, prio_wr, remap_wr;
    logic remap_toggle_bit, status_rd, ebi_refresh_irq;
    logic abort_ff, sel_valid_ff, periph_sel_ff, rom_sel_ff, sram_sel_ff;
    logic area3_sel_ff, remap_state_ff, boot_latched_ff, mc_irq_ff;
    logic undef_f, mis_f, ls0, ls1, ls2, ls3, sk0, sk1, sk2, sk3;
    logic [11:0] prio_wdata, prio_rd;
    logic [3:0] bus_req, xfer_done, acc_valid, bus_gnt_ff, last_src;
    logic [3:0] sticky, win;
    logic [3:0][31:0] acc_addr;
    logic [3:0][1:0] acc_size, acc_kind;
    logic [7:0] ext_cs_ff;
    logic [31:0] sel_addr_ff, abort_addr;
    logic [1:0] abt_size, abt_type;
    int fail_count, checked;
    bit ok;

    assign last_src = {ls3, ls2, ls1, ls0};
    assign sticky = {sk3, sk2, sk1, sk0};

    smc_master_model i_smc_master_model (.ref_clk(ref_clk),
        .bus_gnt_ff(bus_gnt_ff), .bus_req(bus_req), .xfer_done(xfer_done),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_size(acc_size),
        .acc_kind(acc_kind));

    smc_controller i_smc_controller (.ref_clk(ref_clk), .rst_b(rst_b),
        .boot_select_pin(boot_select_pin), .bus_req(bus_req),
        .xfer_done(xfer_done), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_size(acc_size), .acc_kind(acc_kind), .prio_wr(prio_wr),
        .prio_wdata(prio_wdata), .remap_wr(remap_wr),
        .remap_toggle_bit(remap_toggle_bit), .status_rd(status_rd),
        .ebi_refresh_irq(ebi_refresh_irq), .bus_gnt_ff(bus_gnt_ff),
        .abort_ff(abort_ff), .sel_valid_ff(sel_valid_ff),
        .ext_cs_ff(ext_cs_ff), .periph_sel_ff(periph_sel_ff),
        .rom_sel_ff(rom_sel_ff), .sram_sel_ff(sram_sel_ff),
        .area3_sel_ff(area3_sel_ff), .sel_addr_ff(sel_addr_ff),
        .master_priority_reg_ff(prio_rd), .remap_state_ff(remap_state_ff),
        .boot_latched_ff(boot_latched_ff), .abort_address_reg_ff(abort_addr),
        .abort_size_field_ff(abt_size), .abort_type_field_ff(abt_type),
        .undefined_address_flag_ff(undef_f),
        .misaligned_access_flag_ff(mis_f),
        .last_source_core_flag_ff(ls0), .last_source_dma_flag_ff(ls1),
        .last_source_usbhost_flag_ff(ls2), .last_source_ethernet_flag_ff(ls3),
        .sticky_core_abort_flag_ff(sk0), .sticky_dma_abort_flag_ff(sk1),
        .sticky_usbhost_abort_flag_ff(sk2),
        .sticky_ethernet_abort_flag_ff(sk3), .mc_irq_ff(mc_irq_ff));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic do_reset(input logic pin);
        rst_b = 1'b0;
        boot_select_pin = pin;
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        chk(boot_latched_ff, pin);
        chk({remap_state_ff, sticky}, 5'h00);
    endtask : do_reset

    task automatic pulse(ref logic s, input logic d, ref logic ds);
        s = 1'b1;
        ds = d;
        @(negedge ref_clk);
        s = 1'b0;
        @(negedge ref_clk);
    endtask : pulse

    // e: undef, misalign, abort, valid, chip selects, periph, rom, sram, area3
    task automatic acc(input int m, input logic [31:0] a,
        input logic [1:0] sz, input logic [1:0] kd, input logic [15:0] e);
        i_smc_master_model.access(m, a, sz, kd, ok);
        chk(ok, 1'b1);
        chk({abort_ff, sel_valid_ff, ext_cs_ff, periph_sel_ff, rom_sel_ff,
            sram_sel_ff, area3_sel_ff}, e[13:0]);
        if (e[13]) begin
            chk({undef_f, mis_f}, e[15:14]);
            chk(abort_addr, a);
            chk({abt_size, abt_type}, {sz, kd});
            chk(last_src, 32'h1 << m);
        end
        i_smc_master_model.finish_access(m);
    endtask : acc

    task automatic arb(input logic [11:0] p, input logic [3:0] mask,
        input logic [3:0] exp);
        prio_wdata = p;
        pulse(prio_wr, 1'b0, remap_toggle_bit);
        chk(prio_rd, p);
        i_smc_master_model.contend(mask, win);
        chk(win, exp);
    endtask : arb

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        {prio_wr, remap_wr, remap_toggle_bit, status_rd} = 4'h0;
        ebi_refresh_irq = 1'b0;
        rst_b = 1'b0;
        prio_wdata = 12'h000;
        fail_count = 0;
        checked = 0;
        @(negedge ref_clk);
        do_reset(1'b1);
        chk(prio_rd, smc_pkg::PRIO_RST);
        i_smc_master_model.contend(4'hf, win);
        chk(win, 4'h8);
        arb({3'h5, 3'h5, 3'h5, 3'h5}, 4'hf, 4'h1);
        arb({3'h5, 3'h5, 3'h5, 3'h5}, 4'hc, 4'h4);
        arb({3'h7, 3'h7, 3'h7, 3'h0}, 4'hf, 4'h2);
        arb({3'h7, 3'h0, 3'h0, 3'h6}, 4'h7, 4'h1);
        arb({3'h0, 3'h0, 3'h7, 3'h0}, 4'hf, 4'h2);
        acc(0, 32'h1000_0004, W, RD, 16'h1010);
        acc(1, 32'h8000_0008, W, WR, 16'h1800);
        acc(2, 32'hf000_0010, H, WR, 16'h1008);
        acc(3, 32'h0012_3451, B, RD, 16'h1004);
        chk(sel_addr_ff, 32'h0002_3451);
        acc(0, 32'h0020_0000, W, RD, 16'h1002);
        acc(0, 32'h0030_0004, W, RD, 16'h1001);
        acc(0, 32'h0000_0000, W, FE, 16'h1004);
        acc(0, 32'h1000_0002, W, FE, 16'h1010);
        acc(1, 32'h1000_0003, B, RD, 16'h1010);
        pulse(status_rd, 1'b0, remap_toggle_bit);
        acc(1, 32'h0040_0000, W, RD, 16'ha000);
        chk(sticky, 4'h0);
        acc(3, 32'h9000_0000, B, WR, 16'ha000);
        chk(sticky, 4'h2);
        acc(0, 32'he000_0000, W, FE, 16'ha000);
        acc(1, 32'h1000_0002, W, RD, 16'h6000);
        chk(sticky, 4'hb);
        pulse(status_rd, 1'b0, remap_toggle_bit);
        chk(sticky, 4'h0);
        acc(2, 32'h1000_0001, H, WR, 16'h6000);
        acc(0, 32'h2000_0002, W, RD, 16'h6000);
        pulse(remap_wr, 1'b1, remap_toggle_bit);
        chk(remap_state_ff, 1'b1);
        acc(0, 32'h0000_0010, W, RD, 16'h1002);
        acc(0, 32'h0020_0010, W, RD, 16'h1002);
        pulse(remap_wr, 1'b0, remap_toggle_bit);
        chk(remap_state_ff, 1'b1);
        pulse(remap_wr, 1'b1, remap_toggle_bit);
        chk(remap_state_ff, 1'b0);
        acc(0, 32'h0000_0010, W, RD, 16'h1004);
        ebi_refresh_irq = 1'b1;
        @(negedge ref_clk);
        chk(mc_irq_ff, 1'b1);
        ebi_refresh_irq = 1'b0;
        @(negedge ref_clk);
        chk(mc_irq_ff, 1'b0);
        do_reset(1'b0);
        acc(0, 32'h0000_0010, W, RD, 16'h1010);
        end_sim();
    end
endmodule : system_bus_memory_controller_bench
